// File: hdl/home_search_pkg.sv
// package: register map, field positions and state codes for the home search sequencer
package home_search_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off       = 8'h00; // w: cmd pulses
  localparam logic [7:0] mode_off       = 8'h04; // rw: search mode
  localparam logic [7:0] input_mode_off = 8'h08; // rw: input_mode_word
  localparam logic [7:0] main_stat_off  = 8'h0c; // r: main_status_word
  localparam logic [7:0] err_stat_off   = 8'h10; // r: axis_error_status
  localparam logic [7:0] irq_stat_off   = 8'h14; // r, clear on read
  localparam logic [7:0] irq_mask_off   = 8'h18; // rw
  localparam logic [7:0] offset_cnt_off = 8'h1c; // rw: step 4 pulse count
  // ctrl bits
  localparam int cmd_search_bit = 0;
  localparam int cmd_drive_bit  = 1;
  localparam int cmd_stop_bit   = 2;
  localparam int cmd_clear_bit  = 3;
  // mode bits: step enables at even, directions (1 = minus) at odd
  localparam int mode_s1_en = 0;
  localparam int mode_s1_dir = 1;
  localparam int mode_s2_en = 2;
  localparam int mode_s2_dir = 3;
  localparam int mode_s3_en = 4;
  localparam int mode_s3_dir = 5;
  localparam int mode_s4_en = 6;
  localparam int mode_s4_dir = 7;
  // input_mode_word polarity bits (1 = active high), enables are ignored in search
  localparam int pol_near_bit  = 2;
  localparam int pol_home_bit  = 4;
  localparam int pol_index_bit = 7;
  // axis_error_status bits
  localparam int err_lim_plus_bit  = 2;
  localparam int err_lim_minus_bit = 3;
  localparam int err_index_bit     = 7;
  // main_status_word bits
  localparam int busy_lo_bit = 8;
  localparam int busy_hi_bit = 9;
  localparam int err_sum_bit = 4;
  // irq status bits
  localparam int irq_done_bit = 0;
  localparam int irq_err_bit  = 1;
  // execution state codes
  localparam logic [4:0] code_idle    = 5'h00;
  localparam logic [4:0] code_s1      = 5'h03;
  localparam logic [4:0] code_s2_back = 5'h08;
  localparam logic [4:0] code_s2_esc  = 5'h0c;
  localparam logic [4:0] code_s2_find = 5'h0f;
  localparam logic [4:0] code_s3      = 5'h14;
  localparam logic [4:0] code_s4      = 5'h19;
  localparam logic [31:0] offset_cnt_rst = 32'h0000_0000;
  localparam logic [1:0]  resp_okay   = 2'b00;
  localparam logic [1:0]  resp_slverr = 2'b10;
endpackage : home_search_pkg

// File: hdl/home_search.sv
// home search sequencer for one axis with an axi4-lite register slave
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - stuck limit blocks motion, flags limit error except in step 1 and step 2 forward search (taken as limit reached)
// - limit never seen: keep driving forever
// - near-home active at start skips step 1
// - step 1 ends at limit, escape path
// - stuck home: reverse to opposite limit, flag
// - no home: reverse at limit, end opposite
// - index active at step 3 start: error
// - no index: stop at search limit, flag
// - step 3 stops on index falling edge
// - polarities from input mode bits 2,4,7
// - input enable bits ignored during search
// - index error cleared by drive/search/clear
// - busy bits 9:8 high steps 1-4
// - state code 0,3,8,12,15,20,25 reported
//////////////////////////////////////////////////////////////////////////////
module home_search #(
  parameter int addr_w = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [addr_w-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [addr_w-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              near_home_input,
  input  wire logic              home_input,
  input  wire logic              encoder_index_input,
  input  wire logic              limit_plus_input,
  input  wire logic              limit_minus_input,
  input  wire logic              step_pulse,
  output logic                   drive_en,
  output logic                   drive_dir_minus,
  output logic                   irq
);
  if (addr_w < 6) begin : g_addr_w_check
    $error("addr_w too small for register map");
  end

  typedef enum {st_idle, st_s1, st_s2_back, st_s2_esc, st_s2_find, st_s3_arm, st_s3, st_s4} state_t;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit order near, home, index, lim+, lim-, step
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 6'h00;
      pin_sync_reg <= 6'h00;
    end else begin
      pin_meta_reg <= {step_pulse, limit_minus_input, limit_plus_input,
                       encoder_index_input, home_input, near_home_input};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  mode_reg;
  logic [7:0]  input_mode_reg;
  logic [31:0] offset_cnt_reg;
  logic [31:0] pulse_cnt_reg;
  logic [7:0]  err_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic        index_prev_reg;
  state_t      state_reg;
  state_t      state_next;

  // polarity only, enable bits 1,3,5 deliberately unused here
  wire near_act  = pin_sync_reg[0] ~^ input_mode_reg[home_search_pkg::pol_near_bit];
  wire home_act  = pin_sync_reg[1] ~^ input_mode_reg[home_search_pkg::pol_home_bit];
  wire index_act = pin_sync_reg[2] ~^ input_mode_reg[home_search_pkg::pol_index_bit];
  wire lim_plus  = pin_sync_reg[3];
  wire lim_minus = pin_sync_reg[4];
  wire step_s    = pin_sync_reg[5];

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data may arrive in either order
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [addr_w-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [7:0] wr_off = {{(8 - 5){1'b0}}, awaddr_reg[4:2], 2'b00};
  wire wr_ctrl  = wr_go && wr_off == home_search_pkg::ctrl_off && wstrb_reg[0];
  wire wr_mode  = wr_go && wr_off == home_search_pkg::mode_off && wstrb_reg[0];
  wire wr_imode = wr_go && wr_off == home_search_pkg::input_mode_off && wstrb_reg[0];
  wire wr_mask  = wr_go && wr_off == home_search_pkg::irq_mask_off && wstrb_reg[0];
  wire wr_ofs   = wr_go && wr_off == home_search_pkg::offset_cnt_off;
  wire wr_ok    = awaddr_reg[addr_w-1:5] == '0 && wr_off != home_search_pkg::main_stat_off &&
                  wr_off != home_search_pkg::err_stat_off && wr_off != home_search_pkg::irq_stat_off;
  wire cmd_search = wr_ctrl && wdata_reg[home_search_pkg::cmd_search_bit];
  wire cmd_drive  = wr_ctrl && wdata_reg[home_search_pkg::cmd_drive_bit];
  wire cmd_stop   = wr_ctrl && wdata_reg[home_search_pkg::cmd_stop_bit];
  wire cmd_clear  = wr_ctrl && wdata_reg[home_search_pkg::cmd_clear_bit];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= home_search_pkg::resp_okay;
    end else begin
      s_axi_awready <= !aw_held_reg && !aw_take;
      s_axi_wready  <= !w_held_reg && !w_take;
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? home_search_pkg::resp_okay : home_search_pkg::resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  wire        busy = state_reg != st_idle;
  logic [4:0] code;
  always_comb begin
    unique case (state_reg)
      st_idle:    code = home_search_pkg::code_idle;
      st_s1:      code = home_search_pkg::code_s1;
      st_s2_back: code = home_search_pkg::code_s2_back;
      st_s2_esc:  code = home_search_pkg::code_s2_esc;
      st_s2_find: code = home_search_pkg::code_s2_find;
      st_s3_arm:  code = home_search_pkg::code_s3;
      st_s3:      code = home_search_pkg::code_s3;
      st_s4:      code = home_search_pkg::code_s4;
    endcase
  end

  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_off = {{(8 - 5){1'b0}}, s_axi_araddr[4:2], 2'b00};
  wire rd_hit = s_axi_araddr[addr_w-1:5] == '0 && rd_off != home_search_pkg::ctrl_off;
  wire rd_irq = rd_go && rd_hit && rd_off == home_search_pkg::irq_stat_off;
  wire [31:0] main_word = 32'(busy) << home_search_pkg::busy_hi_bit |
                          32'(busy) << home_search_pkg::busy_lo_bit |
                          32'(err_reg != 8'h00 && !busy) << home_search_pkg::err_sum_bit;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_off)
      home_search_pkg::mode_off:       rd_mux = {24'h000000, mode_reg};
      home_search_pkg::input_mode_off: rd_mux = {24'h000000, input_mode_reg};
      home_search_pkg::main_stat_off:  rd_mux = main_word;
      home_search_pkg::err_stat_off:   rd_mux = {19'h00000, code, err_reg};
      home_search_pkg::irq_stat_off:   rd_mux = {30'h00000000, irq_stat_reg};
      home_search_pkg::irq_mask_off:   rd_mux = {30'h00000000, irq_mask_reg};
      home_search_pkg::offset_cnt_off: rd_mux = offset_cnt_reg;
      default:                         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= home_search_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_mux : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? home_search_pkg::resp_okay : home_search_pkg::resp_slverr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  wire s1_minus = mode_reg[home_search_pkg::mode_s1_dir];
  wire s2_minus = mode_reg[home_search_pkg::mode_s2_dir];
  wire s3_minus = mode_reg[home_search_pkg::mode_s3_dir];
  wire s4_minus = mode_reg[home_search_pkg::mode_s4_dir];
  wire s2_fwd_lim = s2_minus ? lim_minus : lim_plus;
  wire s2_rev_lim = s2_minus ? lim_plus : lim_minus;
  wire index_fall = index_prev_reg && !index_act;

  // limit in motion direction: stuck-on limit refuses the move; a dead one never ends it
  logic   dir_next;
  logic   run_next;
  wire    cur_lim = dir_next ? lim_minus : lim_plus;
  logic   err_lim_set;
  logic   err_idx_set;
  logic   done_set;

  // steps after 'cur' in order, next enabled one or idle
  function automatic state_t after(input int cur, input logic [7:0] m, input logic near);
    after = st_idle;
    if (cur < 4 && m[home_search_pkg::mode_s4_en]) after = st_s4;
    if (cur < 3 && m[home_search_pkg::mode_s3_en]) after = st_s3_arm;
    if (cur < 2 && m[home_search_pkg::mode_s2_en]) after = st_s2_find;
    if (cur < 1 && m[home_search_pkg::mode_s1_en] && !near) after = st_s1;
  endfunction : after

  always_comb begin
    state_next  = state_reg;
    err_lim_set = 1'b0;
    err_idx_set = 1'b0;
    done_set    = 1'b0;
    unique case (state_reg)
      st_idle: if (cmd_search) state_next = after(0, mode_reg, near_act);
      st_s1: begin
        if (near_act) state_next = after(1, mode_reg, 1'b0);
        else if (s1_minus ? lim_minus : lim_plus) state_next = st_s2_back;
      end
      st_s2_back: if (home_act) state_next = st_s2_esc;
      else if (s2_rev_lim) begin
        state_next = st_idle;
        err_lim_set = 1'b1;
      end
      st_s2_esc: if (!home_act) state_next = st_s2_find;
      else if (s2_rev_lim) begin
        state_next = st_idle;
        err_lim_set = 1'b1;
      end
      st_s2_find: if (home_act) state_next = after(2, mode_reg, 1'b0);
      else if (s2_fwd_lim) state_next = st_s2_back;
      st_s3_arm: if (index_act) begin
        state_next = st_idle;
        err_idx_set = 1'b1;
      end else state_next = st_s3;
      st_s3: if (index_fall) state_next = after(3, mode_reg, 1'b0);
      else if (cur_lim) begin
        state_next = st_idle;
        err_lim_set = 1'b1;
      end
      st_s4: if (pulse_cnt_reg == 32'h0000_0000) state_next = st_idle;
      else if (cur_lim) begin
        state_next = st_idle;
        err_lim_set = 1'b1;
      end
    endcase
    // stuck home on entry of step 2 forward search goes straight to escape
    if (state_reg != st_s2_find && state_reg != st_s2_back && state_next == st_s2_find && home_act)
      state_next = st_s2_esc;
    if (cmd_stop && busy) state_next = st_idle;
    if (busy && state_next == st_idle) done_set = 1'b1;
  end

  always_comb begin
    unique case (state_reg)
      st_s1:      dir_next = s1_minus;
      st_s2_back: dir_next = !s2_minus;
      st_s2_esc:  dir_next = !s2_minus;
      st_s2_find: dir_next = s2_minus;
      st_s3_arm:  dir_next = s3_minus;
      st_s3:      dir_next = s3_minus;
      st_s4:      dir_next = s4_minus;
      st_idle:    dir_next = 1'b0;
    endcase
    run_next = busy && state_next == state_reg && state_reg != st_s3_arm && !cur_lim;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg       <= st_idle;
      mode_reg        <= 8'h00;
      input_mode_reg  <= 8'h00;
      offset_cnt_reg  <= home_search_pkg::offset_cnt_rst;
      pulse_cnt_reg   <= 32'h0000_0000;
      err_reg         <= 8'h00;
      irq_stat_reg    <= 2'b00;
      irq_mask_reg    <= 2'b00;
      index_prev_reg  <= 1'b0;
      drive_en        <= 1'b0;
      drive_dir_minus <= 1'b0;
      irq             <= 1'b0;
    end else begin
      state_reg       <= state_next;
      index_prev_reg  <= index_act;
      drive_en        <= run_next;
      drive_dir_minus <= dir_next;
      if (wr_mode) mode_reg <= wdata_reg[7:0];
      if (wr_imode) input_mode_reg <= wdata_reg[7:0];
      if (wr_mask) irq_mask_reg <= wdata_reg[1:0];
      if (wr_ofs) offset_cnt_reg <= wdata_reg;
      if (state_next == st_s4 && state_reg != st_s4) pulse_cnt_reg <= offset_cnt_reg;
      else if (state_reg == st_s4 && step_s && drive_en && pulse_cnt_reg != 32'h0000_0000)
        pulse_cnt_reg <= pulse_cnt_reg - 32'h0000_0001;
      if (cmd_search || cmd_drive || cmd_clear) err_reg <= 8'h00;
      if (err_idx_set) err_reg[home_search_pkg::err_index_bit] <= 1'b1;
      if (err_lim_set && dir_next) err_reg[home_search_pkg::err_lim_minus_bit] <= 1'b1;
      if (err_lim_set && !dir_next) err_reg[home_search_pkg::err_lim_plus_bit] <= 1'b1;
      // set wins over the clear-on-read
      irq_stat_reg <= (rd_irq ? 2'b00 : irq_stat_reg) |
                      {err_lim_set || err_idx_set, done_set};
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : home_search

// File: bench/home_search_assertions.sv
// checker: port-level timing and safety properties of the home search block
module home_search_assertions #(
  parameter int addr_w = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [addr_w-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              limit_plus_input,
  input wire logic              limit_minus_input,
  input wire logic              drive_en,
  input wire logic              drive_dir_minus,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////////
  // five cycles covers the two sync stages and the drive register, with a cycle to spare; the drop needs no state step
  a_plus_limit_block: assert property (limit_plus_input [*5] |-> !(drive_en && !drive_dir_minus))
    else $error("drive toward a held plus limit");
  a_minus_limit_block: assert property (limit_minus_input [*5] |-> !(drive_en && drive_dir_minus))
    else $error("drive toward a held minus limit");
  a_reset_quiet: assert property ($rose(aresetn) |-> !drive_en && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset release");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated after it was taken");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated after it was taken");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  a_ctrl_read_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == home_search_pkg::ctrl_off
      |=> s_axi_rresp == home_search_pkg::resp_slverr && s_axi_rdata == 32'h0000_0000)
    else $error("control read not refused");
  c_plus_limit: cover property (limit_plus_input && drive_en);
  c_irq_seen: cover property (irq);
  c_drive_stop: cover property ($fell(drive_en));
endmodule : home_search_assertions

bind home_search home_search_assertions #(.addr_w(addr_w)) chk_i (.*);

// File: bench/axis_sensor_model.sv
// sensor model: axis position with limit, near-home, home and index sensors
module axis_sensor_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       drive_en,
  input  wire logic       drive_dir_minus,
  input  wire logic [2:0] pol,
  input  wire logic [1:0] flt_near,
  input  wire logic [1:0] flt_home,
  input  wire logic [1:0] flt_index,
  input  wire logic [1:0] flt_limit,
  output logic            step_pulse,
  output logic            near_home_input,
  output logic            home_input,
  output logic            encoder_index_input,
  output logic            limit_plus_input,
  output logic            limit_minus_input,
  output int              pos
);
  logic [2:0] phase;
  // fault code: 0 normal, 1 stuck on, 2 stuck off
  function automatic logic fault(input logic [1:0] f, input logic v);
    return (f == 2'd1) ? 1'b1 : (f == 2'd2) ? 1'b0 : v;
  endfunction : fault
  // pol bits: 0 near, 1 home, 2 index; 1 = active high
  assign near_home_input     = fault(flt_near, pos >= 60) ~^ pol[0];
  assign home_input          = fault(flt_home, pos inside {[80:85]}) ~^ pol[1];
  // index stays active for 32 cycles, far longer than the input path delay
  assign encoder_index_input = fault(flt_index, (pos % 20) inside {[10:13]}) ~^ pol[2];
  // travel is bounded only by the hardware limit sensors, no software limit
  assign limit_plus_input    = fault(flt_limit, pos >= 200);
  assign limit_minus_input   = pos <= -200;
  // motion halts in the cycle drive_en drops: no coasting past a sensor
  always_ff @(posedge aclk) begin
    step_pulse <= 1'b0;
    phase      <= drive_en ? phase + 3'd1 : 3'd0;
    if (!aresetn) begin
      pos   <= 0;
      phase <= 3'd0;
    end else if (drive_en && phase == 3'd7) begin
      step_pulse <= 1'b1;
      pos        <= drive_dir_minus ? pos - 1 : pos + 1;
    end
  end
endmodule : axis_sensor_model

// File: bench/home_search_fault_behaviour_test.sv
// testbench: home search sequencer against a faulty-sensor axis model
module home_search_fault_behaviour_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, seen;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, flt_near, flt_home, flt_index, flt_limit;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        near_home_input, home_input, encoder_index_input, limit_plus_input, limit_minus_input;
  logic        step_pulse, drive_en, drive_dir_minus, irq;
  logic [2:0]  pol;
  int          pos, n_mismatch, compares, cycles;
  logic [31:0] imw_tab [2] = '{32'h0000_0094, 32'h0000_002a};
  home_search dut (.*);
  axis_sensor_model model (.*);
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // each channel is released at the edge its own ready is seen
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  task automatic do_reset(input logic [1:0] fn, input logic [1:0] fh, input logic [1:0] fi, input logic [1:0] fl);
    aresetn   <= 1'b0;
    flt_near  <= fn;
    flt_home  <= fh;
    flt_index <= fi;
    flt_limit <= fl;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset
  // leaves the last error status read in rd, codes seen in seen
  // busy_exp: a search refused at once has already ended when status is read
  task automatic search(input logic [31:0] mode, input logic [31:0] imw, input int lim,
                        input logic [1:0] busy_exp = 2'b11);
    int n;
    n    = 0;
    seen = 32'h0;
    pol <= {imw[7], imw[4], imw[2]};
    wr(home_search_pkg::mode_off, mode);
    wr(home_search_pkg::input_mode_off, imw);
    wr(home_search_pkg::offset_cnt_off, 32'h0000_0008);
    wr(home_search_pkg::ctrl_off, 32'h0000_0001);
    rd_reg(home_search_pkg::main_stat_off);
    chk(rd[9:8], busy_exp);
    do begin
      rd_reg(home_search_pkg::err_stat_off);
      seen[rd[12:8]] = 1'b1;
      n++;
    end while (rd[12:8] !== 5'h00 && n < lim);
  endtask : search
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pol} = '0;
    s_axi_wstrb = 4'hf;
    {n_mismatch, compares, cycles} = '0;
    do_reset(2'd0, 2'd0, 2'd0, 2'd0);
    rd_reg(home_search_pkg::mode_off);
    chk(rd, 32'h0);
    rd_reg(home_search_pkg::ctrl_off);
    chk(resp, home_search_pkg::resp_slverr);
    rd_reg(8'h40);
    chk(resp, home_search_pkg::resp_slverr);
    wr(home_search_pkg::main_stat_off, 32'h0000_0001);
    chk(resp, home_search_pkg::resp_slverr);
    // both polarities; enable bits left clear, then set, must not matter
    foreach (imw_tab[i]) begin
      do_reset(2'd0, 2'd0, 2'd0, 2'd0);
      search(32'h0000_0055, imw_tab[i], 3000);
      chk(rd[7:0], 8'h00);
      chk(seen[3] & seen[15] & seen[20] & seen[25], 1);
      chk(pos >= 102 && pos <= 104, 1);
    end
    do_reset(2'd1, 2'd0, 2'd0, 2'd0);
    search(32'h0000_0055, 32'h0000_0094, 3000);
    chk({seen[home_search_pkg::code_s1], rd[7:0]}, 9'h000);
    do_reset(2'd2, 2'd0, 2'd0, 2'd0);
    search(32'h0000_0055, 32'h0000_0094, 3000);
    chk({seen[home_search_pkg::code_s2_back], rd[7:0]}, 9'h100);
    do_reset(2'd0, 2'd1, 2'd0, 2'd0);
    search(32'h0000_0055, 32'h0000_0094, 3000);
    chk(rd[7:0], 8'h08);
    do_reset(2'd0, 2'd2, 2'd0, 2'd0);
    search(32'h0000_0055, 32'h0000_0094, 3000);
    chk(rd[7:0], 8'h08);
    do_reset(2'd0, 2'd0, 2'd1, 2'd0);
    search(32'h0000_0055, 32'h0000_0094, 3000);
    chk({seen[home_search_pkg::code_s4], rd[7:0]}, 9'h080);
    chk(irq, 1'b0);
    wr(home_search_pkg::irq_mask_off, 32'h0000_0003);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    rd_reg(home_search_pkg::irq_stat_off);
    chk(rd[home_search_pkg::irq_err_bit], 1'b1);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(home_search_pkg::ctrl_off, 32'h0000_0008);
    rd_reg(home_search_pkg::err_stat_off);
    chk(rd[7], 1'b0);
    do_reset(2'd0, 2'd0, 2'd2, 2'd0);
    search(32'h0000_0055, 32'h0000_0094, 3000);
    chk(rd[7:0], 8'h04);
    do_reset(2'd0, 2'd0, 2'd0, 2'd1);
    search(32'h0000_0010, 32'h0000_0094, 3000, 2'b00);
    chk({pos, rd[7:0]}, 40'h04);
    do_reset(2'd0, 2'd2, 2'd0, 2'd2);
    search(32'h0000_0004, 32'h0000_0094, 800);
    chk(rd[12:8] != 5'h00 && pos > 250, 1);
    wr(home_search_pkg::ctrl_off, 32'h0000_0004);
    rd_reg(home_search_pkg::main_stat_off);
    chk(rd[9:8], 2'b00);
    final_report();
  end
endmodule : home_search_fault_behaviour_test
